// ==== verilog/tcr_formatter.sv ====
// Tagged capture record formatter: header build, frame path, output
`timescale 1ns/1ps
`include "tcr_regs.svh"

// Operation
// - Ethernet record tag from classification result
// - Tag bits 0-5 hold stream number
// - Tag bits 6-13 hold filter matches
// - Tag bit 14 is CRC hash bit
// - Tag bit 15 is parity hash bit
// - Offset byte written zero, consumers ignore it
// - Pad byte, then frame, aligns layer three
// - Ethernet payload is rlen minus header, two
// - Type bit 7 set when extension follows
// - HDLC record type code is nineteen
// - HDLC tag: hash low, color above
// - HDLC record carries four-byte protocol header
// - HDLC payload is rlen minus header, four
// - Ethernet record type code is sixteen
module tcr_formatter #(
	parameter int FIFO_DEPTH = `TCR_FIFO_DEPTH
) (
	input  wire logic                  SYS_CLK,
	input  wire logic                  RESETN,
	input  wire logic                  CE,
	// Per-frame descriptor
	input  wire logic                  DESC_VALID,
	output logic                       DESC_READY,
	input  wire tcr_pkg::tcr_variant_t DESC_VARIANT,
	input  wire logic [63:0]           TIMESTAMP,
	input  wire logic [7:0]            PORT_FLAGS,
	input  wire logic [15:0]           FRAME_LEN,
	input  wire logic [5:0]            STREAM_NUM,
	input  wire logic [7:0]            FILTER_MATCH,
	input  wire logic                  HASH_CRC_BIT,
	input  wire logic                  HASH_PARITY_BIT,
	input  wire logic [3:0]            HASH_VALUE,
	input  wire logic [11:0]           FILTER_COLOR,
	input  wire logic [31:0]           PROTO_HDR,
	input  wire logic                  EXT_PRESENT,
	input  wire logic [63:0]           EXT_HDR,
	// Captured frame bytes from the link side
	input  wire logic                  IN_VALID,
	output logic                       IN_READY,
	input  wire logic [7:0]            IN_DATA,
	input  wire logic                  IN_LAST,
	// Record bytes toward the capture buffer
	output logic                       OUT_VALID,
	input  wire logic                  OUT_READY,
	output logic [7:0]                 OUT_DATA,
	output logic                       OUT_LAST,
	// Status
	output logic                       LEN_ERROR,
	output logic [15:0]                RECORD_COUNT
);
	import tcr_pkg::*;

	localparam int PM = `TCR_PREFIX_MAX;

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		tcr_state_t          st;       // Sequence state
		logic [PM-1:0][7:0]  pre;      // Record bytes before frame
		logic [4:0]          plen;     // Prefix byte count
		logic [4:0]          idx;      // Prefix byte index
		logic [15:0]         rem;      // Frame bytes still owed
		logic                desc_rdy; // Descriptor can be taken
		logic                ovld;     // Output byte valid
		logic [7:0]          odat;     // Output byte
		logic                olast;    // Last byte of record
		logic                lerr;     // Length mismatch pulse
		logic [15:0]         rcnt;     // Finished records
	} tcr_fmt_st_t;

	tcr_fmt_st_t r_q;     // Registered state
	tcr_fmt_st_t r_d;     // Next state
	logic        adv;     // Output stage can take a byte
	logic        pop;     // Take a byte from the FIFO
	logic        f_last;  // FIFO head ends the frame
	logic [7:0]  f_byte;  // FIFO head data

	tcr_fifo_if #(.W(9)) fi ();

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Tag value for the chosen variant
	function automatic logic [15:0] make_tag(input tcr_variant_t v);
		logic [15:0] t;
		t = 16'h0000;
		if (v == TCR_VAR_ETH) begin
			t[`TCR_TAG_STREAM_LSB +: 6] = STREAM_NUM;
			t[`TCR_TAG_FILTER_LSB +: 8] = FILTER_MATCH;
			t[`TCR_TAG_HASHA_BIT] = HASH_CRC_BIT;
			t[`TCR_TAG_HASHB_BIT] = HASH_PARITY_BIT;
		end else begin
			t[`TCR_TAG_HVAL_LSB +: 4]   = HASH_VALUE;
			t[`TCR_TAG_COLOR_LSB +: 12] = FILTER_COLOR;
		end
		return t;
	endfunction : make_tag

	// Bytes between fixed header and frame for the variant
	function automatic logic [4:0] body_pre(input tcr_variant_t v);
		return (v == TCR_VAR_ETH) ? `TCR_ETH_PRE_BYTES
			: `TCR_HDLC_PRE_BYTES;
	endfunction : body_pre

	// Whole prefix, byte 0 leaves first
	function automatic logic [PM-1:0][7:0] build_prefix(
		input tcr_variant_t v
	);
		logic [PM-1:0][7:0] p;
		logic [15:0]        rlen;
		logic [15:0]        tag;
		logic [4:0]         b;
		p    = '0;
		tag  = make_tag(v);
		// frame bytes equal rlen less header, ext, two
		// frame bytes equal rlen less header, ext, four
		rlen = 16'(`TCR_FIXED_HDR_BYTES) + FRAME_LEN
			+ 16'(body_pre(v))
			+ (EXT_PRESENT ? 16'(`TCR_EXT_BYTES) : 16'h0000);
		// Timestamp, low byte first like the host word order
		for (int i = 0; i < 8; i++) begin
			p[i] = TIMESTAMP[8*i +: 8];
		end
		p[8][6:0] = (v == TCR_VAR_ETH) ? `TCR_TYPE_ETH
			: `TCR_TYPE_HDLC;
		p[8][`TCR_TYPE_EXT_BIT] = EXT_PRESENT;
		p[9]  = PORT_FLAGS;
		p[10] = rlen[15:8];
		p[11] = rlen[7:0];
		p[12] = tag[15:8];
		p[13] = tag[7:0];
		p[14] = FRAME_LEN[15:8];
		p[15] = FRAME_LEN[7:0];
		b = `TCR_FIXED_HDR_BYTES;
		if (EXT_PRESENT) begin
			for (int i = 0; i < 8; i++) begin
				p[16 + i] = EXT_HDR[63 - 8*i -: 8];
			end
			b = b + `TCR_EXT_BYTES;
		end
		if (v == TCR_VAR_ETH) begin
			p[b] = `TCR_OFFSET_VAL;
			p[b + 5'h01] = `TCR_PAD_VAL;
		end else begin
			for (int i = 0; i < 4; i++) begin
				p[b + 5'(i)] = PROTO_HDR[31 - 8*i -: 8];
			end
		end
		return p;
	endfunction : build_prefix

	// ------------------------------------------------------------
	// Frame buffer
	// ------------------------------------------------------------

	// Link bytes queue here while the header goes out
	tcr_fifo #(
		.W (9),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk   (SYS_CLK),
		.rst_n (RESETN),
		.ce    (CE),
		.f     (fi.fifo)
	);

	assign fi.wr_valid = IN_VALID;
	assign fi.wr_data  = {IN_LAST, IN_DATA};
	assign fi.rd_ready = pop;
	assign f_last      = fi.rd_data[8];
	assign f_byte      = fi.rd_data[7:0];

	// ------------------------------------------------------------
	// Record sequencer
	// ------------------------------------------------------------
	always_comb begin
		r_d      = r_q;
		r_d.lerr = 1'b0;
		pop      = 1'b0;
		adv      = !r_q.ovld || OUT_READY;
		// Byte consumed downstream
		if (adv) begin
			r_d.ovld  = 1'b0;
			r_d.olast = 1'b0;
		end
		case (r_q.st)
			// Wait for the next frame's descriptor
			TCR_IDLE: begin
				if (DESC_VALID && r_q.desc_rdy) begin
					r_d.desc_rdy = 1'b0;
					r_d.pre      = build_prefix(DESC_VARIANT);
					r_d.plen     = `TCR_FIXED_HDR_BYTES
						+ body_pre(DESC_VARIANT)
						+ (EXT_PRESENT ? `TCR_EXT_BYTES : 5'h00);
					r_d.idx      = 5'h00;
					r_d.rem      = FRAME_LEN;
					r_d.st       = TCR_PREFIX;
				end
			end
			// Header, extension and offset/pad or protocol bytes
			TCR_PREFIX: begin
				if (adv) begin
					r_d.ovld = 1'b1;
					r_d.odat = r_q.pre[r_q.idx];
					r_d.idx  = r_q.idx + 5'h01;
					if (r_q.idx == r_q.plen - 5'h01) begin
						// Empty frame still needs its bytes drained
						r_d.olast = (r_q.rem == 16'h0000);
						r_d.st    = (r_q.rem == 16'h0000) ? TCR_DRAIN
							: TCR_BODY;
					end
				end
			end
			// Frame bytes straight after the prefix
			TCR_BODY: begin
				if (adv && fi.rd_valid) begin
					pop       = 1'b1;
					r_d.ovld  = 1'b1;
					r_d.odat  = f_byte;
					r_d.rem   = r_q.rem - 16'h0001;
					r_d.olast = (r_q.rem == 16'h0001);
					if (r_q.rem == 16'h0001) begin
						// Longer frame than declared: drop the tail
						r_d.lerr = !f_last;
						r_d.st   = f_last ? TCR_DONE : TCR_DRAIN;
					end else if (f_last) begin
						// Short frame: keep rlen honest with zeros
						r_d.lerr = 1'b1;
						r_d.st   = TCR_ZFILL;
					end
				end
			end
			// Zero fill for a frame that ended early
			TCR_ZFILL: begin
				if (adv) begin
					r_d.ovld  = 1'b1;
					r_d.odat  = 8'h00;
					r_d.rem   = r_q.rem - 16'h0001;
					r_d.olast = (r_q.rem == 16'h0001);
					if (r_q.rem == 16'h0001) begin
						r_d.st = TCR_DONE;
					end
				end
			end
			// Discard bytes up to the frame end marker
			TCR_DRAIN: begin
				if (fi.rd_valid) begin
					pop = 1'b1;
					if (f_last) begin
						r_d.st = TCR_DONE;
					end
				end
			end
			// Record closed, count it and reopen
			TCR_DONE: begin
				r_d.rcnt     = r_q.rcnt + 16'h0001;
				r_d.desc_rdy = 1'b1;
				r_d.st       = TCR_IDLE;
			end
			default: begin
				r_d.st       = TCR_IDLE;
				r_d.desc_rdy = 1'b1;
			end
		endcase
		// Frozen clock enable must not eat FIFO bytes
		if (!CE) begin
			pop = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			r_q          <= '0;
			r_q.st       <= TCR_IDLE;
			r_q.desc_rdy <= 1'b1;
		end else if (CE) begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------
	assign DESC_READY   = r_q.desc_rdy;
	assign IN_READY     = fi.wr_ready;
	assign OUT_VALID    = r_q.ovld;
	assign OUT_DATA     = r_q.odat;
	assign OUT_LAST     = r_q.olast;
	assign LEN_ERROR    = r_q.lerr;
	assign RECORD_COUNT = r_q.rcnt;

endmodule : tcr_formatter

// ==== verilog/tcr_regs.svh ====
// Constants of the tagged capture record formatter
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH

// ----------------------------------------------------------------
// Record type byte
// ----------------------------------------------------------------
`define TCR_TYPE_ETH        7'h10
`define TCR_TYPE_HDLC       7'h13
`define TCR_TYPE_EXT_BIT    7

// ----------------------------------------------------------------
// Record section sizes in bytes
// ----------------------------------------------------------------
`define TCR_FIXED_HDR_BYTES 5'h10
`define TCR_EXT_BYTES       5'h08
`define TCR_ETH_PRE_BYTES   5'h02
`define TCR_HDLC_PRE_BYTES  5'h04
`define TCR_PREFIX_MAX      28

// ----------------------------------------------------------------
// Tag field positions
// ----------------------------------------------------------------
`define TCR_TAG_STREAM_LSB  0
`define TCR_TAG_FILTER_LSB  6
`define TCR_TAG_HASHA_BIT   14
`define TCR_TAG_HASHB_BIT   15
`define TCR_TAG_HVAL_LSB    0
`define TCR_TAG_COLOR_LSB   4

// ----------------------------------------------------------------
// Fill values and buffer depth
// ----------------------------------------------------------------
`define TCR_OFFSET_VAL      8'h00
`define TCR_PAD_VAL         8'h00
`define TCR_FIFO_DEPTH      16

`endif

// ==== verilog/tcr_pkg.sv ====
// Types of the tagged capture record formatter
package tcr_pkg;

	// Record variant chosen per descriptor
	typedef enum logic {
		TCR_VAR_ETH,
		TCR_VAR_HDLC
	} tcr_variant_t;

	// Formatter sequence
	typedef enum logic [2:0] {
		TCR_IDLE,
		TCR_PREFIX,
		TCR_BODY,
		TCR_ZFILL,
		TCR_DRAIN,
		TCR_DONE
	} tcr_state_t;

endpackage : tcr_pkg

// ==== verilog/tcr_fifo_if.sv ====
// Valid/ready carrier between the formatter and its byte FIFO
`timescale 1ns/1ps
interface tcr_fifo_if #(parameter int W = 9);
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] wr_data;
	logic         rd_valid;
	logic         rd_ready;
	logic [W-1:0] rd_data;

	modport fifo (input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data);
	modport user (output wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data);
endinterface : tcr_fifo_if

// ==== verilog/tcr_fifo.sv ====
// Byte FIFO with registered write-side ready
`timescale 1ns/1ps
module tcr_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	tcr_fifo_if.fifo  f
);
	import tcr_pkg::*;

	localparam int AW = $clog2(D);

	// All FIFO state in one record
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;  // Storage
		logic [AW-1:0]       wp;   // Write pointer
		logic [AW-1:0]       rp;   // Read pointer
		logic [AW:0]         cnt;  // Fill level
		logic                rdy;  // Room left, registered
	} tcr_fifo_st_t;

	tcr_fifo_st_t r_q;
	tcr_fifo_st_t r_d;
	logic         push;
	logic         pop;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		r_d  = r_q;
		push = f.wr_valid && r_q.rdy;
		pop  = f.rd_ready && (r_q.cnt != '0);
		// Write into the free slot
		if (push) begin
			r_d.mem[r_q.wp] = f.wr_data;
			r_d.wp          = (r_q.wp == AW'(D - 1)) ? '0 : r_q.wp + 1'b1;
		end
		// Retire the oldest word
		if (pop) begin
			r_d.rp = (r_q.rp == AW'(D - 1)) ? '0 : r_q.rp + 1'b1;
		end
		r_d.cnt = r_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// Ready is registered from the next fill level, so it never over-fills
		r_d.rdy = (r_d.cnt < (AW+1)'(D));
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q     <= '0;
			r_q.rdy <= 1'b1;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	assign f.wr_ready = r_q.rdy;
	assign f.rd_valid = (r_q.cnt != '0);
	assign f.rd_data  = r_q.mem[r_q.rp];

endmodule : tcr_fifo

// ==== verif/tcr_sink_model.sv ====
// Capture buffer stand-in that takes record bytes
`timescale 1ns/1ps
module tcr_sink_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic slow,
	output logic      ready
);
	// ---------
	// Take side
	// ---------
	// offset byte content is never read
	// Falling edge moves, slow mode stalls about two in three
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
		end else begin
			ready <= !slow || $urandom_range(2) == 0;
		end
	end
endmodule : tcr_sink_model

// ==== verif/tcr_formatter_chk.sv ====
// Port checker of the record formatter
`timescale 1ns/1ps
`include "tcr_regs.svh"
module tcr_formatter_chk (
	input wire logic                  SYS_CLK,
	input wire logic                  RESETN,
	input wire logic                  CE,
	input wire logic                  DESC_VALID,
	input wire logic                  DESC_READY,
	input wire tcr_pkg::tcr_variant_t DESC_VARIANT,
	input wire logic [15:0]           FRAME_LEN,
	input wire logic [5:0]            STREAM_NUM,
	input wire logic [7:0]            FILTER_MATCH,
	input wire logic                  HASH_CRC_BIT,
	input wire logic                  HASH_PARITY_BIT,
	input wire logic [3:0]            HASH_VALUE,
	input wire logic [11:0]           FILTER_COLOR,
	input wire logic                  EXT_PRESENT,
	input wire logic                  OUT_VALID,
	input wire logic                  OUT_READY,
	input wire logic [7:0]            OUT_DATA,
	input wire logic                  OUT_LAST,
	input wire logic                  LEN_ERROR,
	input wire logic [15:0]           RECORD_COUNT
);
	import tcr_pkg::*;
	// -------------
	// Field capture
	// -------------
	logic        take, acc, hd_q, ext_q, hd_n, ext_n;
	logic [15:0] idx_q, rlen_q, tag_q, rlen_n, tag_n, pre;
	assign take = CE && DESC_VALID && DESC_READY;
	assign acc  = CE && OUT_VALID && OUT_READY;
	// Offset byte index
	assign pre = ext_q ? 16'h0018 : 16'h0010;
	// Fields wait at take and go live with the record's first byte,
	// since a stalled last byte may still leave after the next take
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			{hd_q, ext_q, idx_q, rlen_q, tag_q} <= '0;
			{hd_n, ext_n, rlen_n, tag_n} <= '0;
		end else begin
			if (take) begin
				hd_n   <= DESC_VARIANT == TCR_VAR_HDLC;
				ext_n  <= EXT_PRESENT;
				rlen_n <= FRAME_LEN + (EXT_PRESENT ? 16'h0018 : 16'h0010)
					+ (DESC_VARIANT == TCR_VAR_HDLC ? 16'h0004 : 16'h0002);
				tag_n  <= DESC_VARIANT == TCR_VAR_HDLC ?
					{FILTER_COLOR, HASH_VALUE} :
					{HASH_PARITY_BIT, HASH_CRC_BIT, FILTER_MATCH, STREAM_NUM};
			end
			if (acc && idx_q == 16'h0000) begin
				{hd_q, ext_q, rlen_q, tag_q} <= {hd_n, ext_n, rlen_n, tag_n};
			end
			// Byte index within the record on the wire
			if (acc) begin
				idx_q <= OUT_LAST ? 16'h0000 : idx_q + 16'h0001;
			end
		end
	end
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	sequence s_last;
		CE && OUT_VALID && OUT_READY && OUT_LAST;
	endsequence
	sequence s_done;
		!DESC_READY ##1 DESC_READY;
	endsequence
	out_hold_a: assert property (OUT_VALID && !(CE && OUT_READY) |=>
		OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST))
		else $error("stalled byte changed");
	desc_take_a: assert property (take |=> !DESC_READY ##1 OUT_VALID)
		else $error("descriptor answer wrong");
	type_byte_a: assert property (
		OUT_VALID && idx_q == 16'h0008 |-> OUT_DATA ==
		{ext_q, hd_q ? `TCR_TYPE_HDLC : `TCR_TYPE_ETH})
		else $error("type byte wrong");
	rec_len_a: assert property (
		OUT_VALID && idx_q[15:1] == 15'h0005 |->
		OUT_DATA == (idx_q[0] ? rlen_q[7:0] : rlen_q[15:8]))
		else $error("record length wrong");
	tag_hi_a: assert property (
		OUT_VALID && idx_q == 16'h000C |-> OUT_DATA == tag_q[15:8])
		else $error("tag high byte wrong");
	tag_lo_a: assert property (
		OUT_VALID && idx_q == 16'h000D |-> OUT_DATA == tag_q[7:0])
		else $error("tag low byte wrong");
	pad_zero_a: assert property (
		OUT_VALID && !hd_q && (idx_q == pre || idx_q == pre + 16'h0001)
		|-> OUT_DATA == 8'h00)
		else $error("offset or pad wrong");
	err_pulse_a: assert property (LEN_ERROR && CE |=> !LEN_ERROR)
		else $error("length error too long");
	rec_done_a: assert property (s_done |-> !OUT_VALID || OUT_LAST)
		else $error("record end wrong");
	rec_count_a: assert property (s_done |->
		RECORD_COUNT == $past(RECORD_COUNT) + 16'h0001)
		else $error("record count wrong");
	last_once_a: assert property (s_last |=> !OUT_LAST)
		else $error("last byte repeated");
endmodule : tcr_formatter_chk

// ==== verif/tb_tcr_formatter.sv ====
// Self-checking bench of the record formatter
`timescale 1ns/1ps
`include "tcr_regs.svh"
module tb_tcr_formatter;
	import tcr_pkg::*;
	logic         sys_clk, resetn, ce, slow, d_valid, d_ready;
	logic         crc_b, par_b, ext_p, in_valid, in_ready, in_last;
	logic         o_valid, o_ready, o_last, len_err;
	tcr_variant_t variant;
	logic [63:0]  ts, ext_hdr;
	logic [7:0]   flags, filt, in_data, o_data;
	logic [15:0]  f_len, rec_cnt;
	logic [5:0]   stream;
	logic [3:0]   hval;
	logic [11:0]  color;
	logic [31:0]  proto;
	logic [8:0]   exp_q[$];
	int           error_cnt, checks, lerr, k;
	tcr_formatter DUT (.SYS_CLK(sys_clk), .RESETN(resetn), .CE(ce),
		.DESC_VALID(d_valid), .DESC_READY(d_ready),
		.DESC_VARIANT(variant), .TIMESTAMP(ts), .PORT_FLAGS(flags),
		.FRAME_LEN(f_len), .STREAM_NUM(stream), .FILTER_MATCH(filt),
		.HASH_CRC_BIT(crc_b), .HASH_PARITY_BIT(par_b),
		.HASH_VALUE(hval), .FILTER_COLOR(color), .PROTO_HDR(proto),
		.EXT_PRESENT(ext_p), .EXT_HDR(ext_hdr), .IN_VALID(in_valid),
		.IN_READY(in_ready), .IN_DATA(in_data), .IN_LAST(in_last),
		.OUT_VALID(o_valid), .OUT_READY(o_ready), .OUT_DATA(o_data),
		.OUT_LAST(o_last), .LEN_ERROR(len_err), .RECORD_COUNT(rec_cnt));
	tcr_sink_model u_sink (.clk(sys_clk), .rst_n(resetn), .slow(slow),
		.ready(o_ready));
	// -----
	// Tasks
	// -----
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			$display("ERROR %0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask : cmp
	task wrap_up;
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// One record: declared length n, s bytes really sent
	task automatic rec(input logic h, input logic x, input int n, s);
		logic [15:0] rl, tg;
		logic [7:0]  ty;
		logic [7:0]  e[$], f[$];
		@(negedge sys_clk);
		variant = h ? TCR_VAR_HDLC : TCR_VAR_ETH;
		ext_p = x;
		f_len = 16'(n);
		ts = {$urandom, $urandom};
		{flags, stream, filt, crc_b, par_b, hval, color, proto, ext_hdr} =
			136'({$urandom, $urandom, $urandom, $urandom, $urandom});
		rl = f_len + (x ? 16'h0018 : 16'h0010) + (h ? 16'h0004 : 16'h0002);
		tg = h ? {color, hval} : {par_b, crc_b, filt, stream};
		ty = {x, h ? `TCR_TYPE_HDLC : `TCR_TYPE_ETH};
		for (int i = 0; i < s; i++) f.push_back(8'($urandom));
		for (int i = 0; i < 8; i++) e.push_back(ts[8*i +: 8]);
		e = {e, ty, flags, rl[15:8], rl[7:0], tg[15:8], tg[7:0],
			f_len[15:8], f_len[7:0]};
		for (int i = 7; i >= 0 && x; i--) e.push_back(ext_hdr[8*i +: 8]);
		if (h) for (int i = 3; i >= 0; i--) e.push_back(proto[8*i +: 8]);
		else e = {e, 8'h00, 8'h00};
		// Short frames are filled with zero
		for (int i = 0; i < n; i++) e.push_back(i < s ? f[i] : 8'h00);
		foreach (e[j]) exp_q.push_back({j == e.size() - 1, e[j]});
		d_valid = 1'b1;
		for (k = 0; k < 999 && !d_ready; k++) @(negedge sys_clk);
		@(negedge sys_clk);
		d_valid = 1'b0;
		// Frame bytes held until taken
		for (int i = 0; i < s; i++) begin
			in_valid = 1'b1;
			in_data = f[i];
			in_last = i == s - 1;
			for (k = 0; k < 999 && !in_ready; k++) @(negedge sys_clk);
			@(negedge sys_clk);
		end
		in_valid = 1'b0;
		for (k = 0; k < 9999 && !d_ready; k++) @(negedge sys_clk);
	endtask : rec
	// -------
	// Monitor
	// -------
	always @(posedge sys_clk) begin
		if (resetn && ce && o_valid === 1'b1 && o_ready) begin
			if (exp_q.size() == 0) cmp(16'hFFFF, 16'h0000);
			else cmp({7'h00, o_last, o_data}, {7'h00, exp_q.pop_front()});
		end
		if (len_err === 1'b1) lerr++;
	end
	// ---------
	// Main flow
	// ---------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		{resetn, d_valid, in_valid, in_last, slow, crc_b, par_b} = '0;
		{ts, ext_hdr, flags, filt, in_data, f_len, stream} = '0;
		{hval, color, proto, ext_p} = '0;
		variant = TCR_VAR_ETH;
		ce = 1'b1;
		void'($urandom(32'hC15F));
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		resetn = 1'b1;
		@(negedge sys_clk);
		cmp({d_ready, in_ready, o_valid, len_err, rec_cnt[11:0]}, 16'hC000);
		for (int v = 0; v < 4; v++) rec(v[0], v[1], 5 + v, 5 + v);
		slow = 1'b1;
		rec(1'b0, 1'b0, 40, 40);
		rec(1'b1, 1'b0, 6, 3);
		rec(1'b0, 1'b1, 4, 7);
		// A stalled last byte may still wait after the record closes
		for (k = 0; k < 999 && exp_q.size() != 0; k++) @(negedge sys_clk);
		cmp(rec_cnt, 16'h0007);
		cmp(16'(lerr), 16'h0002);
		cmp(16'(exp_q.size()), 16'h0000);
		wrap_up();
	end
	// Hang guard, about twenty thousand cycles
	initial begin
		#160000;
		error_cnt++;
		wrap_up();
	end
endmodule : tb_tcr_formatter
bind tcr_formatter tcr_formatter_chk u_chk (.SYS_CLK(SYS_CLK),
	.RESETN(RESETN), .CE(CE), .DESC_VALID(DESC_VALID),
	.DESC_READY(DESC_READY), .DESC_VARIANT(DESC_VARIANT),
	.FRAME_LEN(FRAME_LEN), .STREAM_NUM(STREAM_NUM),
	.FILTER_MATCH(FILTER_MATCH), .HASH_CRC_BIT(HASH_CRC_BIT),
	.HASH_PARITY_BIT(HASH_PARITY_BIT), .HASH_VALUE(HASH_VALUE),
	.FILTER_COLOR(FILTER_COLOR), .EXT_PRESENT(EXT_PRESENT),
	.OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
	.OUT_LAST(OUT_LAST), .LEN_ERROR(LEN_ERROR),
	.RECORD_COUNT(RECORD_COUNT));
